// File: hw/ee_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM engine
// Assumes: 125 MHz system clock, link clocked by the bus clock pin
// Notes:   Geometry, timing, bit slots and the pointer reset value live here

package ee_pkg;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int ADDR_W     = 13;
  localparam int PAGE_W     = 5;
  localparam int PAGE_BYTES = 32;
  localparam int PTR_HI_W   = ADDR_W - 8;

  // Device-type code; value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEF = 4'h6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_TIME_NS = 40000;
  localparam int WRITE_CYC     = WRITE_TIME_NS / CLK_PERIOD_NS;

  // ****************************************
  // Bit slot positions within a byte frame
  // ****************************************
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [ADDR_W-1:0] PTR_RST = 13'h0000;

  // Link-side frame states
  typedef enum {
    EE_IDLE,
    EE_CTRL,
    EE_ADRH,
    EE_ADRL,
    EE_WDATA,
    EE_RDATA
  } ee_state_t;

  // Pending page write handed to the system side
  typedef struct packed {
    logic [ADDR_W-PAGE_W-1:0] page;
    logic [PAGE_BYTES-1:0]    mask;
  } ee_wreq_t;

  // Bus line pair as seen by the system side
  typedef struct packed {
    logic scl;
    logic sda;
  } ee_line_t;

endpackage : ee_pkg

// File: hw/ee_rw_engine.sv
// Purpose: Command engine of a two-wire serial EEPROM slave, 8K x 8
// Assumes: Bus clock pin clocks the link side; system clock times writes
// Notes:   Page buffer and array are read across domains only while stable

`timescale 1ns/10ps

// Behaviour
// - Control byte: type, selects, direction; ack
// - High then low address byte load pointer
// - Stop starts write; no ack while busy
// - Protected write acked, no cycle, ready
// - Byte write leaves pointer after byte
// - Short write rewrites page, others kept
// - Up to 32 bytes buffered until Stop
// - Data bytes bump five low bits, wrap
// - Page write wraps inside its page
// - Protect input high blocks whole array
// - Protect input sampled at Stop only
// - Polling control byte acked once idle
// - Direction bit one selects read types
// - Current read returns byte at pointer
// - Master nack and Stop end read
// - Random read: address write, restart, read
// - Random read leaves pointer after byte
// - Master ack requests next sequential byte
// - Sequential read wraps top to zero
// - Ack only matching type and selects
// - Upper three high address bits ignored
// - Release data line on master nack
module ee_rw_engine #(
  parameter logic [3:0]  DEV_TYPE  = ee_pkg::DEV_TYPE_DEF,
  parameter int unsigned WRITE_CYC = ee_pkg::WRITE_CYC
) (
  // System clock and reset
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  // Two-wire link
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  // Straps
  input  wire logic wp_in,
  input  wire logic chip_select_bit0_in,
  input  wire logic chip_select_bit1_in,
  input  wire logic chip_select_bit2_in,
  // Status
  output logic      busy_out
);

  localparam int CNT_W = $clog2(WRITE_CYC + 1);
  localparam int AW    = ee_pkg::ADDR_W;
  localparam int PW    = ee_pkg::PAGE_W;

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]              mem_q  [2**AW];
  logic [7:0]              pbuf_q [ee_pkg::PAGE_BYTES];

  // System side
  ee_pkg::ee_line_t        ln_s1_q;
  ee_pkg::ee_line_t        ln_s2_q;
  ee_pkg::ee_line_t        ln_p_q;
  logic                    wp_s1_q;
  logic                    wp_s2_q;
  logic                    pend_s1_q;
  logic                    pend_s2_q;
  logic                    rdy_q;
  logic                    stop;
  logic                    busy_q;
  logic                    busy_d;
  logic                    cyc_q;
  logic                    cyc_d;
  logic                    tog_q;
  logic                    tog_d;
  logic [CNT_W-1:0]        cnt_q;
  logic [CNT_W-1:0]        cnt_d;
  logic                    wr_en;

  // Link side
  logic                    rstn_l1_q;
  logic                    rstn_l2_q;
  logic [2:0]              cs_l1_q;
  logic [2:0]              cs_l2_q;
  logic                    cyc_l1_q;
  logic                    cyc_l2_q;
  logic                    tog_l1_q;
  logic                    tog_l2_q;
  logic                    seen_q;
  logic                    seen_d;
  logic                    sda_p_q;
  logic                    rs_q;
  logic                    rs_d;
  logic                    oe_q;
  logic                    oe_d;
  ee_pkg::ee_state_t       st_q;
  ee_pkg::ee_state_t       st_d;
  logic [3:0]              bit_q;
  logic [3:0]              bit_d;
  logic [7:0]              sh_q;
  logic [7:0]              sh_d;
  logic [7:0]              tx_q;
  logic [7:0]              tx_d;
  logic [AW-1:0]           ptr_q;
  logic [AW-1:0]           ptr_d;
  logic                    ack_q;
  logic                    ack_d;
  logic                    pend_q;
  logic                    pend_d;
  ee_pkg::ee_wreq_t        wreq_q;
  ee_pkg::ee_wreq_t        wreq_d;
  logic                    pb_we;
  logic [7:0]              byte_w;
  logic                    restart;

  // ****************************************
  // System side: pin synchronisers
  // ****************************************

  // Two flops on every pin seen by the system clock except reset
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ln_s1_q   <= '1;
      ln_s2_q   <= '1;
      ln_p_q    <= '1;
      wp_s1_q   <= 1'b0;
      wp_s2_q   <= 1'b0;
      pend_s1_q <= 1'b0;
      pend_s2_q <= 1'b0;
      rdy_q     <= 1'b0;
    end else begin
      ln_s1_q   <= '{scl: scl_in, sda: sda_in};
      ln_s2_q   <= ln_s1_q;
      ln_p_q    <= ln_s2_q;
      wp_s1_q   <= wp_in;
      wp_s2_q   <= wp_s1_q;
      pend_s1_q <= pend_q;
      pend_s2_q <= pend_s1_q;
      rdy_q     <= 1'b1;
    end
  end

  // Data rising while clock stays high
  assign stop = ln_p_q.scl & ln_s2_q.scl & ~ln_p_q.sda & ln_s2_q.sda;

  // ****************************************
  // System side: write cycle engine
  // ****************************************

  // Commit timing, busy and handshake with link side
  always_comb begin
    busy_d = busy_q;
    cyc_d  = cyc_q;
    cnt_d  = cnt_q;
    tog_d  = tog_q ^ stop;
    wr_en  = 1'b0;
    if (busy_q) begin
      wr_en = (cnt_q < CNT_W'(ee_pkg::PAGE_BYTES))
              && wreq_q.mask[cnt_q[PW-1:0]];
      if (cnt_q == CNT_W'(WRITE_CYC - 1)) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
    if (stop && pend_s2_q && !cyc_q) begin
      cyc_d = 1'b1;
      if (!wp_s2_q) begin
        busy_d = 1'b1;
        cnt_d  = '0;
      end
    end else if (cyc_q && !busy_q && !pend_s2_q) begin
      cyc_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      busy_q <= 1'b0;
      cyc_q  <= 1'b0;
      cnt_q  <= '0;
      tog_q  <= 1'b0;
    end else begin
      busy_q <= busy_d;
      cyc_q  <= cyc_d;
      cnt_q  <= cnt_d;
      tog_q  <= tog_d;
    end
  end

  // Masked bytes of the page go to the array, rest untouched
  always_ff @(posedge clk_sys_in) begin
    if (wr_en) begin
      mem_q[{wreq_q.page, cnt_q[PW-1:0]}] <= pbuf_q[cnt_q[PW-1:0]];
    end
  end

  assign busy_out = busy_q;

  // ****************************************
  // Link side: synchronisers
  // ****************************************

  // Reset, selects and cycle flag on the bus clock
  always_ff @(posedge scl_in) begin
    rstn_l1_q <= resetn_in;
    rstn_l2_q <= rstn_l1_q;
    cs_l1_q   <= {chip_select_bit2_in, chip_select_bit1_in, chip_select_bit0_in};
    cs_l2_q   <= cs_l1_q;
    cyc_l1_q  <= cyc_q;
    cyc_l2_q  <= cyc_l1_q;
    tog_l2_q  <= tog_l1_q;
    sda_p_q   <= sda_in;
  end

  // Stop toggle first flop on the falling edge
  always_ff @(negedge scl_in) begin
    tog_l1_q <= tog_q;
  end

  // ****************************************
  // Link side: frame state machine
  // ****************************************

  assign byte_w  = {sh_q[6:0], sda_in};
  assign restart = rs_q | (tog_l2_q != seen_q);

  // Bit counting, byte decode and pointer moves
  always_comb begin
    st_d   = st_q;
    bit_d  = bit_q;
    sh_d   = {sh_q[6:0], sda_in};
    tx_d   = tx_q;
    ptr_d  = ptr_q;
    ack_d  = ack_q;
    pend_d = pend_q & ~cyc_l2_q;
    wreq_d = wreq_q;
    seen_d = tog_l2_q;
    pb_we  = 1'b0;
    if (restart) begin
      st_d  = ee_pkg::EE_CTRL;
      // Stop path crosses late, one bit already in
      bit_d = rs_q ? ee_pkg::BIT_FIRST : ee_pkg::BIT_FIRST + 4'h1;
      ack_d = 1'b0;
      if (rs_q) begin
        pend_d      = 1'b0;
        wreq_d.mask = '0;
      end
    end else if (st_q == ee_pkg::EE_IDLE) begin
      bit_d = '0;
    end else if (bit_q < ee_pkg::BIT_LAST) begin
      bit_d = bit_q + 1'b1;
      tx_d  = {tx_q[6:0], 1'b0};
    end else if (bit_q == ee_pkg::BIT_LAST) begin
      bit_d = ee_pkg::BIT_ACK;
      ack_d = 1'b1;
      unique case (st_q)
        ee_pkg::EE_CTRL: begin
          ack_d = (byte_w[7:4] == DEV_TYPE)
                  && (byte_w[3:1] == cs_l2_q)
                  && !(pend_q || cyc_l2_q);
        end
        ee_pkg::EE_ADRH: begin
          ptr_d[AW-1:8] = byte_w[ee_pkg::PTR_HI_W-1:0];
        end
        ee_pkg::EE_ADRL: begin
          ptr_d[7:0]  = byte_w;
          wreq_d.mask = '0;
        end
        ee_pkg::EE_WDATA: begin
          pb_we                    = 1'b1;
          wreq_d.mask[ptr_q[PW-1:0]] = 1'b1;
          wreq_d.page              = ptr_q[AW-1:PW];
          ptr_d[PW-1:0]            = ptr_q[PW-1:0] + 1'b1;
          pend_d                   = 1'b1;
        end
        ee_pkg::EE_RDATA: begin
          ack_d = 1'b0;
        end
        default: begin
          ack_d = 1'b0;
        end
      endcase
    end else begin
      bit_d = '0;
      unique case (st_q)
        ee_pkg::EE_CTRL: begin
          if (!ack_q) begin
            st_d = ee_pkg::EE_IDLE;
          end else if (sh_q[0]) begin
            st_d  = ee_pkg::EE_RDATA;
            tx_d  = mem_q[ptr_q];
            ptr_d = ptr_q + 1'b1;
          end else begin
            st_d = ee_pkg::EE_ADRH;
          end
        end
        ee_pkg::EE_ADRH: begin
          st_d = ee_pkg::EE_ADRL;
        end
        ee_pkg::EE_ADRL: begin
          st_d = ee_pkg::EE_WDATA;
        end
        ee_pkg::EE_WDATA: begin
          st_d = ee_pkg::EE_WDATA;
        end
        ee_pkg::EE_RDATA: begin
          if (!sda_in) begin
            tx_d  = mem_q[ptr_q];
            ptr_d = ptr_q + 1'b1;
          end else begin
            st_d = ee_pkg::EE_IDLE;
          end
        end
        default: begin
          st_d = ee_pkg::EE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge scl_in) begin
    if (!rstn_l2_q) begin
      st_q   <= ee_pkg::EE_IDLE;
      bit_q  <= '0;
      sh_q   <= '0;
      tx_q   <= '0;
      ptr_q  <= ee_pkg::PTR_RST;
      ack_q  <= 1'b0;
      pend_q <= 1'b0;
      wreq_q <= '0;
      seen_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      tx_q   <= tx_d;
      ptr_q  <= ptr_d;
      ack_q  <= ack_d;
      pend_q <= pend_d;
      wreq_q <= wreq_d;
      seen_q <= seen_d;
    end
  end

  // Page buffer fill, overwritten in arrival order
  always_ff @(posedge scl_in) begin
    if (pb_we) begin
      pbuf_q[ptr_q[PW-1:0]] <= byte_w;
    end
  end

  // ****************************************
  // Link side: falling edge drive
  // ****************************************

  // Repeated start seen and data line drive
  always_comb begin
    rs_d = sda_p_q & ~sda_in;
    oe_d = 1'b0;
    if (st_q == ee_pkg::EE_RDATA) begin
      oe_d = (bit_q < ee_pkg::BIT_ACK) & ~tx_q[7];
    end else if (st_q != ee_pkg::EE_IDLE) begin
      oe_d = (bit_q == ee_pkg::BIT_ACK) & ack_q;
    end
  end

  always_ff @(negedge scl_in) begin
    if (!rstn_l2_q) begin
      rs_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      rs_q <= rs_d;
      oe_q <= oe_d;
    end
  end

  // Open drain: only ever pull low, released under reset
  assign sda_out    = 1'b0;
  assign sda_oe_out = oe_q & rdy_q;

endmodule : ee_rw_engine

// File: tb/ee_rw_engine_properties.sv
// Purpose: Port checks for the EEPROM engine
// Assumes: Bound to ee_rw_engine, system clock domain
// Notes:   Stop seen by sampling the link lines
`timescale 1ns/10ps
module ee_rw_engine_properties #(
  parameter int unsigned WRITE_CYC = 64
) (
  // Clock, reset, link
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Straps and status
  input wire logic wp_in,
  input wire logic chip_select_bit0_in,
  input wire logic chip_select_bit1_in,
  input wire logic chip_select_bit2_in,
  input wire logic busy_out
);
  // ****
  // Helpers
  // ****
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  logic [15:0] bcnt_q, bcnt_d;
  logic [3:0]  stop_q, stop_d;
  logic        sda_q;
  // Busy length and Stop age counters
  always_comb begin
    bcnt_d = busy_out ? bcnt_q + 16'h0001 : 16'h0000;
    stop_d = stop_q + {3'h0, stop_q != 4'hf};
    if (!resetn_in) stop_d = 4'hf;
    else if (scl_in && sda_in && !sda_q) stop_d = 4'h0;
  end
  always_ff @(posedge clk_sys_in) begin
    bcnt_q <= bcnt_d;
    stop_q <= stop_d;
    sda_q  <= sda_in;
  end
  sequence s_busy_hold;
    busy_out [*8];
  endsequence
  // ****
  // Checks
  // ****
  AST_OD_LOW: assert property (sda_out == 1'b0) else $error("data value not low");
  AST_RST_QUIET: assert property (disable iff (1'b0) !resetn_in |=> !busy_out && !sda_oe_out)
    else $error("active during reset");
  AST_BUSY_HOLD: assert property ($rose(busy_out) |-> s_busy_hold)
    else $error("busy too short");
  AST_BUSY_LEN: assert property ($fell(busy_out) |-> bcnt_q == WRITE_CYC)
    else $error("busy length wrong");
  AST_BUSY_AFTER_STOP: assert property ($rose(busy_out) |-> stop_q < 4'hb)
    else $error("busy without stop");
  AST_WP_BLOCK: assert property (wp_in [*8] |-> !$rose(busy_out))
    else $error("write while protected");
  AST_QUIET_BUSY: assert property (busy_out && $past(busy_out) |-> !sda_oe_out)
    else $error("ack while busy");
  AST_OE_SCL_LOW: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("drive began with clock high");
endmodule : ee_rw_engine_properties

// File: tb/ee_i2c_master_model.sv
// Purpose: Bus master model for the two-wire link
// Assumes: Pull-up on data, clock idles high between frames
// Notes:   Tasks are called by the bench
`timescale 1ns/10ps
module ee_i2c_master_model (
  // Link
  output logic      scl_out,
  output logic      sda_oe_out,
  input  wire logic sda_in
);
  // ****
  // Bus cycles
  // ****
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  // Clock pulses with data released
  task automatic pulses(input int n);
    repeat (n) begin
      #24 scl_out = 1'b0;
      #24 scl_out = 1'b1;
    end
  endtask : pulses
  // Start or repeated Start, clock left low
  task automatic start_c();
    sda_oe_out = 1'b0;
    #12 scl_out = 1'b1;
    #24 sda_oe_out = 1'b1;
    #24 scl_out = 1'b0;
  endtask : start_c
  // One bit slot, line sampled at clock rise
  task automatic bit_x(input logic b, output logic r);
    #12 sda_oe_out = !b;
    #12 scl_out = 1'b1;
    r = sda_in;
    #24 scl_out = 1'b0;
  endtask : bit_x
  // Byte out, returns acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : send
  // Byte in, then master ack or nack
  task automatic recv(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(!ack, r);
  endtask : recv
  // Stop then bus free time
  task automatic stop_c();
    #12 sda_oe_out = 1'b1;
    #12 scl_out = 1'b1;
    #24 sda_oe_out = 1'b0;
    #72;
  endtask : stop_c
endmodule : ee_i2c_master_model

// File: tb/ee_rw_engine_bench.sv
// Purpose: Self-checking bench for the EEPROM engine
// Assumes: Short write cycle, selects strapped to 5
// Notes:   Link driven by the master model
`timescale 1ns/10ps
module ee_rw_engine_bench;
  logic       clk, resetn, wp, scl, m_oe, d_oe, busy, a;
  logic [7:0] d;
  wire        sda = !(m_oe | d_oe);
  int         miscompares = 0;
  int         comparisons = 0;
  always #4 clk = !clk;
  ee_rw_engine #(.WRITE_CYC(64)) i_ee_rw_engine (
    .clk_sys_in(clk), .resetn_in(resetn), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe_out(d_oe), .wp_in(wp), .chip_select_bit0_in(1'b1),
    .chip_select_bit1_in(1'b0), .chip_select_bit2_in(1'b1), .busy_out(busy));
  ee_i2c_master_model i_ee_i2c_master_model (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bit_is(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask : bit_is
  function automatic logic [7:0] ctl(input logic rd);
    return {ee_pkg::DEV_TYPE_DEF, 3'h5, rd};
  endfunction : ctl
  task automatic hdr(input logic [15:0] adr);
    i_ee_i2c_master_model.start_c();
    i_ee_i2c_master_model.send(ctl(1'b0), a);
    bit_is(a, 1'b1);
    i_ee_i2c_master_model.send(adr[15:8], a);
    bit_is(a, 1'b1);
    i_ee_i2c_master_model.send(adr[7:0], a);
    bit_is(a, 1'b1);
  endtask : hdr
  task automatic rdq(input logic [7:0] e [$]);
    i_ee_i2c_master_model.start_c();
    i_ee_i2c_master_model.send(ctl(1'b1), a);
    bit_is(a, 1'b1);
    foreach (e[i]) begin
      i_ee_i2c_master_model.recv(i < e.size() - 1, d);
      chk(d, e[i]);
    end
    i_ee_i2c_master_model.stop_c();
  endtask : rdq
  // Acknowledge polling, master repeats until acked
  task automatic poll(output int n);
    n = 0;
    repeat (40) begin
      i_ee_i2c_master_model.start_c();
      i_ee_i2c_master_model.send(ctl(1'b0), a);
      i_ee_i2c_master_model.stop_c();
      if (a === 1'b1) return;
      n++;
    end
    miscompares++;
    print_verdict();
  endtask : poll
  task automatic wr(input logic [15:0] adr, input logic [7:0] q [$], input logic bz,
                    input logic wp_set);
    int n;
    hdr(adr);
    foreach (q[i]) begin
      i_ee_i2c_master_model.send(q[i], a);
      bit_is(a, 1'b1);
    end
    i_ee_i2c_master_model.stop_c();
    @(posedge clk);
    #1 wp = wp_set;
    bit_is(busy, bz);
    poll(n);
    if (bz) bit_is(n > 0, 1'b1);
  endtask : wr
  // ****
  // Scenarios
  // ****
  task automatic t_select();
    logic [7:0] bad [2];
    bad = '{{~ee_pkg::DEV_TYPE_DEF, 4'ha}, {ee_pkg::DEV_TYPE_DEF, 4'h4}};
    foreach (bad[i]) begin
      i_ee_i2c_master_model.start_c();
      i_ee_i2c_master_model.send(bad[i], a);
      bit_is(a, 1'b0);
      i_ee_i2c_master_model.stop_c();
    end
    $display("test select done");
  endtask : t_select
  task automatic t_page();
    logic [7:0] q [$];
    for (int i = 0; i < 33; i++) q.push_back(8'(i));
    wr(16'he01e, '{8'h11, 8'h22, 8'h33, 8'h44}, 1'b1, 1'b0);
    hdr(16'h001e);
    rdq('{8'h11, 8'h22});
    hdr(16'h0000);
    rdq('{8'h33, 8'h44});
    wr(16'h0100, q, 1'b1, 1'b0);
    hdr(16'h0100);
    rdq('{8'h20, 8'h01});
    $display("test page done");
  endtask : t_page
  task automatic t_pointer();
    wr(16'h0105, '{8'ha5}, 1'b1, 1'b0);
    rdq('{8'h06});
    hdr(16'h0104);
    rdq('{8'h04});
    rdq('{8'ha5});
    wr(16'h1fff, '{8'h3c}, 1'b1, 1'b0);
    hdr(16'h1fff);
    rdq('{8'h3c, 8'h33});
    $display("test pointer done");
  endtask : t_pointer
  task automatic t_protect();
    @(posedge clk);
    #1 wp = 1'b1;
    wr(16'h0105, '{8'hff}, 1'b0, 1'b1);
    hdr(16'h0105);
    rdq('{8'ha5});
    @(posedge clk);
    #1 wp = 1'b0;
    wr(16'h0106, '{8'h77}, 1'b1, 1'b1);
    hdr(16'h0106);
    rdq('{8'h77});
    $display("test protect done");
  endtask : t_protect
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    wp = 1'b0;
    fork
      repeat (5) @(posedge clk);
      i_ee_i2c_master_model.pulses(3);
    join
    @(posedge clk);
    #1 resetn = 1'b1;
    // Clock the released reset into the link side
    i_ee_i2c_master_model.pulses(3);
    t_select();
    t_page();
    t_pointer();
    t_protect();
    print_verdict();
  end
endmodule : ee_rw_engine_bench
bind ee_rw_engine ee_rw_engine_properties #(.WRITE_CYC(WRITE_CYC)) i_ee_rw_engine_properties (
  .clk_sys_in, .resetn_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .wp_in,
  .chip_select_bit0_in, .chip_select_bit1_in, .chip_select_bit2_in, .busy_out);
